// >>> src/vme_core_if.sv
/*
 carrier between the entry engine, the gate checker and the stack memory.
 assumes all users sit on the same clock.
*/
`timescale 1ns/1ps
interface vme_core_if;
    vme_pkg::vme_word_type gate;
    logic gate_gp;
    logic gate_task;
    logic gate_intr;
    logic [15:0] err_sel;
    logic we;
    logic [4:0] widx;
    vme_pkg::vme_word_type wdata;
    logic [4:0] ridx;
    vme_pkg::vme_word_type rdata;
    modport core (output gate, we, widx, wdata, ridx,
        input gate_gp, gate_task, gate_intr, err_sel, rdata);
    modport chk (input gate, output gate_gp, gate_task, gate_intr, err_sel);
    modport stk (input we, widx, wdata, ridx, output rdata);
endinterface : vme_core_if

// >>> src/vme_defines.svh
/*
 constants of the virtual legacy mode exception entry block: register
 byte offsets, field positions, slot indices and reset values.
 assumes a 32-bit classic wishbone slave with an 8-bit byte address.
*/
// What this block does
// - events dispatch through a trap, interrupt or task gate taken from the table
// - with the virtual interrupt mechanism off, maskable interrupts act as exceptions
// - trap or interrupt gate entry first switches to protected level 0
// - push ip, cs, flags, sp, ss and four data segments on level-0 stack
// - then clear the four data segment registers
// - return with cleared data segments raises no trap
// - clear virtual, nested, resume, step flags; interrupt gate also clears enable
// - conforming or nonzero-level target raises a protection fault instead
// - that fault reports the target code selector as error code
// - return reloads flags and segments from level-0 images, maybe resuming virtual mode
// - return changes the virtual flag only at privilege level 0
// - task gate first stores current flags, virtual flag set, in current task segment
// - task switch writes the interrupted task selector into the link field
// - task switch loads new flags, clearing the virtual flag
// - then set the nested flag and run the handler task
// - return with nested flag set switches back to the linked task
`ifndef VME_DEFINES_SVH
`define VME_DEFINES_SVH
`define VME_A_CTRL 8'h00
`define VME_A_STAT 8'h04
`define VME_A_GATE 8'h08
`define VME_A_GOFS 8'h0c
`define VME_A_ST0 8'h10
`define VME_A_ST8 8'h30
`define VME_A_TSSC 8'h40
`define VME_A_NTFL 8'h44
`define VME_A_LINK 8'h4c
`define VME_A_ERR 8'h50
`define VME_A_STK0 8'h54
`define VME_A_SS0 8'h58
`define VME_A_CPL 8'h5c
`define VME_CTRL_VIM 0
`define VME_CTRL_EXC 1
`define VME_CTRL_INTERRUPT_EXIT_INSTR 2
`define VME_STAT_BUSY 0
`define VME_STAT_GP 1
`define VME_STAT_CPL_LO 4
`define VME_STAT_CPL_HI 5
`define VME_F_TF 8
`define VME_F_IF 9
`define VME_F_NT 14
`define VME_F_RF 16
`define VME_F_VM 17
`define VME_G_TYP_LO 0
`define VME_G_TYP_HI 1
`define VME_G_CONF 2
`define VME_G_DPL_LO 3
`define VME_G_DPL_HI 4
`define VME_G_SEL_LO 16
`define VME_G_SEL_HI 31
`define VME_GT_TRAP 2'h0
`define VME_GT_INT 2'h1
`define VME_GT_TASK 2'h2
`define VME_GT_BAD 2'h3
`define VME_ST_IP 4'h0
`define VME_ST_CS 4'h1
`define VME_ST_FL 4'h2
`define VME_ST_SP 4'h3
`define VME_ST_SS 4'h4
`define VME_ST_ES 4'h5
`define VME_ST_GS 4'h8
`define VME_LAST 4'h8
`define VME_TSS_BASE 5'h10
`define VME_STK_WORDS 32
`define VME_FRAME_BYTES 32'h24
`define VME_CPL0 2'h0
`define VME_CPL_V 2'h3
`endif

// >>> src/vme_entry.sv
/*
 exception and interrupt entry and return engine for virtual legacy mode,
 with its machine state reachable over a classic wishbone slave.
 assumes software loads the gate for the pending vector before raising it.
*/
`timescale 1ns/1ps
`include "vme_defines.svh"
module vme_entry (
    input wire logic REF_CLK, // 10 MHz clock
    input wire logic SYS_RST, // sync reset, high
    input wire logic HW_INT, // maskable request, async level
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write
    input wire logic [7:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    output logic VM_MODE, // virtual legacy mode
    output logic [1:0] CPL_O, // privilege level
    output logic GP_FAULT, // sticky protection fault
    output logic BUSY // sequence running
);
    vme_core_if c ();
    vme_gate_chk u_chk (
        .c(c)
    );
    vme_stack u_stk (
        .clk(REF_CLK),
        .c(c)
    );

    vme_pkg::vme_state_type state_ff, nxt_state;
    vme_pkg::vme_word_type st_ff [0:8];
    vme_pkg::vme_word_type gate_ff, gofs_ff, ntfl_ff, stk0_ff, ss0_ff;
    vme_pkg::vme_word_type tssc_ff, link_ff, err_ff, dat_ff, rd_word, fl;
    logic [1:0] cpl_ff;
    logic [3:0] cnt_ff;
    logic vim_ff, gp_ff, exc_ff, interrupt_exit_instr_ff, int_s1_ff, int_s2_ff, ack_ff, busy_ff;
    logic idle, wb_req, wb_wr, ctrl_wr, int_take, last, counting;

    function automatic vme_pkg::vme_word_type lane_merge(input vme_pkg::vme_word_type old,
        input vme_pkg::vme_word_type nw, input logic [3:0] sel);
        vme_pkg::vme_word_type r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    function automatic logic is_st(input logic [7:0] a);
        return (a >= `VME_A_ST0) && (a <= `VME_A_ST8);
    endfunction : is_st

    function automatic logic [3:0] st_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `VME_A_ST0;
        return d[5:2];
    endfunction : st_idx

    assign fl = st_ff[`VME_ST_FL];
    assign idle = state_ff == vme_pkg::S_IDLE;
    // bus is served only between sequences
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff & idle;
    assign wb_wr = wb_req & WB_WE_I;
    assign ctrl_wr = wb_wr & (WB_ADR_I == `VME_A_CTRL) & WB_SEL_I[0];
    assign int_take = int_s2_ff & fl[`VME_F_IF] & ~vim_ff;
    assign last = cnt_ff == `VME_LAST;
    assign counting = (state_ff == vme_pkg::S_PUSH) | (state_ff == vme_pkg::S_TSAVE) |
        (state_ff == vme_pkg::S_POP) | (state_ff == vme_pkg::S_TPOP);
    assign c.gate = gate_ff;

    // stack port steering
    always_comb begin
        c.we = 1'b0;
        c.widx = WB_ADR_I[6:2];
        c.ridx = WB_ADR_I[6:2];
        c.wdata = lane_merge(c.rdata, WB_DAT_I, WB_SEL_I);
        unique case (state_ff)
            vme_pkg::S_IDLE: c.we = wb_wr & WB_ADR_I[7];
            vme_pkg::S_PUSH: begin
                c.we = 1'b1;
                c.widx = {1'b0, cnt_ff};
                c.wdata = st_ff[cnt_ff];
            end
            vme_pkg::S_TSAVE: begin
                c.we = 1'b1;
                c.widx = `VME_TSS_BASE + {1'b0, cnt_ff};
                c.wdata = st_ff[cnt_ff];
            end
            vme_pkg::S_POP: c.ridx = {1'b0, cnt_ff};
            vme_pkg::S_TPOP: c.ridx = `VME_TSS_BASE + {1'b0, cnt_ff};
            vme_pkg::S_CHK, vme_pkg::S_CPL0, vme_pkg::S_CLRSEG, vme_pkg::S_CLRFLG,
            vme_pkg::S_GP, vme_pkg::S_TLINK, vme_pkg::S_TLOAD, vme_pkg::S_TSETNT: begin
            end
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            vme_pkg::S_IDLE: begin
                if (interrupt_exit_instr_ff) begin
                    nxt_state = fl[`VME_F_NT] ? vme_pkg::S_TPOP : vme_pkg::S_POP;
                end else if (exc_ff | int_take) begin
                    nxt_state = vme_pkg::S_CHK;
                end
            end
            vme_pkg::S_CHK: begin
                if (c.gate_gp) begin
                    nxt_state = vme_pkg::S_GP;
                end else if (c.gate_task) begin
                    nxt_state = vme_pkg::S_TSAVE;
                end else begin
                    nxt_state = vme_pkg::S_CPL0;
                end
            end
            vme_pkg::S_CPL0: nxt_state = vme_pkg::S_PUSH;
            vme_pkg::S_PUSH: nxt_state = last ? vme_pkg::S_CLRSEG : vme_pkg::S_PUSH;
            vme_pkg::S_CLRSEG: nxt_state = vme_pkg::S_CLRFLG;
            vme_pkg::S_TSAVE: nxt_state = last ? vme_pkg::S_TLINK : vme_pkg::S_TSAVE;
            vme_pkg::S_TLINK: nxt_state = vme_pkg::S_TLOAD;
            vme_pkg::S_TLOAD: nxt_state = vme_pkg::S_TSETNT;
            vme_pkg::S_POP, vme_pkg::S_TPOP: nxt_state = last ? vme_pkg::S_IDLE : state_ff;
            vme_pkg::S_CLRFLG, vme_pkg::S_GP, vme_pkg::S_TSETNT: nxt_state = vme_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_ff <= vme_pkg::S_IDLE;
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_state != vme_pkg::S_IDLE;
            cnt_ff <= (counting & ~last) ? cnt_ff + 4'h1 : 4'h0;
        end
    end

    // pin synchroniser
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            int_s1_ff <= 1'b0;
            int_s2_ff <= 1'b0;
        end else begin
            int_s1_ff <= HW_INT;
            int_s2_ff <= int_s1_ff;
        end
    end

    // pending commands and sticky fault; a set beats a clear
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            exc_ff <= 1'b0;
            interrupt_exit_instr_ff <= 1'b0;
            gp_ff <= 1'b0;
        end else begin
            exc_ff <= (ctrl_wr & WB_DAT_I[`VME_CTRL_EXC]) | (exc_ff & ~(idle & ~interrupt_exit_instr_ff));
            interrupt_exit_instr_ff <= (ctrl_wr & WB_DAT_I[`VME_CTRL_INTERRUPT_EXIT_INSTR]) | (interrupt_exit_instr_ff & ~idle);
            gp_ff <= (state_ff == vme_pkg::S_GP) | (gp_ff & ~(wb_wr & WB_SEL_I[0] &
                (WB_ADR_I == `VME_A_STAT) & WB_DAT_I[`VME_STAT_GP]));
        end
    end

    // software configuration
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            vim_ff <= 1'b0;
            gate_ff <= 32'h0;
            gofs_ff <= 32'h0;
            ntfl_ff <= 32'h0;
            stk0_ff <= 32'h0;
            ss0_ff <= 32'h0;
        end else if (wb_wr) begin
            unique case (WB_ADR_I)
                `VME_A_CTRL: vim_ff <= WB_SEL_I[0] ? WB_DAT_I[`VME_CTRL_VIM] : vim_ff;
                `VME_A_GATE: gate_ff <= lane_merge(gate_ff, WB_DAT_I, WB_SEL_I);
                `VME_A_GOFS: gofs_ff <= lane_merge(gofs_ff, WB_DAT_I, WB_SEL_I);
                `VME_A_NTFL: ntfl_ff <= lane_merge(ntfl_ff, WB_DAT_I, WB_SEL_I);
                `VME_A_STK0: stk0_ff <= lane_merge(stk0_ff, WB_DAT_I, WB_SEL_I);
                `VME_A_SS0: ss0_ff <= lane_merge(ss0_ff, WB_DAT_I, WB_SEL_I);
                default: begin
                end
            endcase
        end
    end

    // machine state: entry, task switch and return
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i <= `VME_LAST; i++) begin
                st_ff[i] <= 32'h0;
            end
            cpl_ff <= `VME_CPL0;
            tssc_ff <= 32'h0;
            link_ff <= 32'h0;
            err_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                vme_pkg::S_IDLE: begin
                    if (wb_wr & is_st(WB_ADR_I)) begin
                        st_ff[st_idx(WB_ADR_I)] <= lane_merge(st_ff[st_idx(WB_ADR_I)],
                            WB_DAT_I, WB_SEL_I);
                    end
                    if (wb_wr & (WB_ADR_I == `VME_A_CPL) & WB_SEL_I[0]) begin
                        cpl_ff <= WB_DAT_I[1:0];
                    end
                    if (wb_wr & (WB_ADR_I == `VME_A_TSSC)) begin
                        tssc_ff <= lane_merge(tssc_ff, WB_DAT_I, WB_SEL_I);
                    end
                end
                vme_pkg::S_CPL0: cpl_ff <= `VME_CPL0;
                vme_pkg::S_CLRSEG: begin
                    for (int i = `VME_ST_ES; i <= `VME_ST_GS; i++) begin
                        st_ff[i] <= 32'h0;
                    end
                    st_ff[`VME_ST_SP] <= stk0_ff - `VME_FRAME_BYTES;
                    st_ff[`VME_ST_SS] <= ss0_ff;
                    st_ff[`VME_ST_CS] <= {16'h0, c.err_sel};
                    st_ff[`VME_ST_IP] <= gofs_ff;
                end
                vme_pkg::S_CLRFLG: begin
                    st_ff[`VME_ST_FL][`VME_F_VM] <= 1'b0;
                    st_ff[`VME_ST_FL][`VME_F_NT] <= 1'b0;
                    st_ff[`VME_ST_FL][`VME_F_RF] <= 1'b0;
                    st_ff[`VME_ST_FL][`VME_F_TF] <= 1'b0;
                    st_ff[`VME_ST_FL][`VME_F_IF] <= fl[`VME_F_IF] & ~c.gate_intr;
                end
                vme_pkg::S_GP: err_ff <= {16'h0, c.err_sel};
                vme_pkg::S_TLINK: begin
                    link_ff <= tssc_ff;
                    tssc_ff <= {16'h0, c.err_sel};
                end
                vme_pkg::S_TLOAD: begin
                    st_ff[`VME_ST_FL] <= ntfl_ff;
                    st_ff[`VME_ST_FL][`VME_F_VM] <= 1'b0;
                    cpl_ff <= `VME_CPL0;
                end
                vme_pkg::S_TSETNT: st_ff[`VME_ST_FL][`VME_F_NT] <= 1'b1;
                vme_pkg::S_POP, vme_pkg::S_TPOP: begin
                    // zero data selectors are loaded as they are, no trap
                    st_ff[cnt_ff] <= c.rdata;
                    if (cnt_ff == `VME_ST_FL) begin
                        st_ff[cnt_ff][`VME_F_VM] <= (cpl_ff == `VME_CPL0) ?
                            c.rdata[`VME_F_VM] : fl[`VME_F_VM];
                    end
                    if (last) begin
                        cpl_ff <= fl[`VME_F_VM] ? `VME_CPL_V : st_ff[`VME_ST_CS][1:0];
                        if (state_ff == vme_pkg::S_TPOP) begin
                            tssc_ff <= link_ff;
                        end
                    end
                end
                vme_pkg::S_CHK, vme_pkg::S_PUSH, vme_pkg::S_TSAVE: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0;
        if (WB_ADR_I[7]) begin
            rd_word = c.rdata;
        end else if (is_st(WB_ADR_I)) begin
            rd_word = st_ff[st_idx(WB_ADR_I)];
        end else begin
            unique case (WB_ADR_I)
                `VME_A_CTRL: rd_word[`VME_CTRL_VIM] = vim_ff;
                `VME_A_STAT: begin
                    rd_word[`VME_STAT_BUSY] = busy_ff;
                    rd_word[`VME_STAT_GP] = gp_ff;
                    rd_word[`VME_STAT_CPL_HI:`VME_STAT_CPL_LO] = cpl_ff;
                end
                `VME_A_GATE: rd_word = gate_ff;
                `VME_A_GOFS: rd_word = gofs_ff;
                `VME_A_TSSC: rd_word = tssc_ff;
                `VME_A_NTFL: rd_word = ntfl_ff;
                `VME_A_LINK: rd_word = link_ff;
                `VME_A_ERR: rd_word = err_ff;
                `VME_A_STK0: rd_word = stk0_ff;
                `VME_A_SS0: rd_word = ss0_ff;
                `VME_A_CPL: rd_word[1:0] = cpl_ff;
                default: rd_word = 32'h0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= wb_req;
            if (wb_req & ~WB_WE_I) begin
                dat_ff <= rd_word;
            end
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;
    assign VM_MODE = fl[`VME_F_VM];
    assign CPL_O = cpl_ff;
    assign GP_FAULT = gp_ff;
    assign BUSY = busy_ff;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    a_cpl_before_push: assert property (
        state_ff == vme_pkg::S_PUSH |-> cpl_ff == `VME_CPL0)
        else $error("push while not at level 0");
    a_push_image: assert property (
        state_ff == vme_pkg::S_PUSH |-> c.we && c.widx == {1'b0, cnt_ff})
        else $error("push slot wrong");
    a_segs_cleared: assert property (
        state_ff == vme_pkg::S_CLRSEG |=> st_ff[5] == 0 && st_ff[6] == 0 &&
        st_ff[7] == 0 && st_ff[8] == 0)
        else $error("data segments not cleared");
    a_flags_cleared: assert property (
        state_ff == vme_pkg::S_CLRFLG |=> !VM_MODE && !fl[`VME_F_NT] &&
        !fl[`VME_F_TF] && !fl[`VME_F_RF] && (c.gate_intr -> !fl[`VME_F_IF]))
        else $error("entry flags not cleared");
    a_bad_target: assert property (
        idle && nxt_state == vme_pkg::S_CHK && c.gate_gp |=> ##2 gp_ff && idle)
        else $error("bad gate entered handler");
    a_fault_code: assert property (
        state_ff == vme_pkg::S_GP |=> err_ff[15:0] == $past(c.err_sel))
        else $error("fault error code wrong");
    a_vm_kept: assert property (
        idle && nxt_state == vme_pkg::S_POP && cpl_ff != `VME_CPL0 |->
        ##10 VM_MODE == $past(VM_MODE, 10))
        else $error("virtual flag changed above level 0");
    a_link_field: assert property (
        state_ff == vme_pkg::S_TLINK |=> link_ff == $past(tssc_ff))
        else $error("link field wrong");
    a_nested_set: assert property (
        state_ff == vme_pkg::S_TLOAD |=> ##1 fl[`VME_F_NT] && !VM_MODE && idle)
        else $error("nested flag not set");
    a_entry_atomic: assert property (
        state_ff == vme_pkg::S_CHK && !c.gate_gp && !c.gate_task |=>
        (state_ff != vme_pkg::S_IDLE)[*8] ##1 (state_ff != vme_pkg::S_IDLE)[*4] ##1 idle)
        else $error("entry sequence broken");
endmodule : vme_entry

// >>> src/vme_gate_chk.sv
/*
 decodes the selected gate descriptor and judges its target.
 assumes the gate word is stable while the engine is busy.
*/
`timescale 1ns/1ps
`include "vme_defines.svh"
module vme_gate_chk (
    vme_core_if.chk c // gate in, verdict out
);
    logic [1:0] kind;
    assign kind = c.gate[`VME_G_TYP_HI:`VME_G_TYP_LO];
    assign c.gate_task = kind == `VME_GT_TASK;
    assign c.gate_intr = kind == `VME_GT_INT;
    assign c.err_sel = c.gate[`VME_G_SEL_HI:`VME_G_SEL_LO];
    // unusable gate kinds fault like a bad target
    assign c.gate_gp = (kind == `VME_GT_BAD) | (~c.gate_task & (c.gate[`VME_G_CONF] |
        (c.gate[`VME_G_DPL_HI:`VME_G_DPL_LO] != `VME_CPL0)));
endmodule : vme_gate_chk

// >>> src/vme_pkg.sv
/*
 types of the exception entry block.
 assumes vme_defines.svh for the numbers.
*/
package vme_pkg;
    typedef enum logic [3:0] {S_IDLE, S_CHK, S_CPL0, S_PUSH, S_CLRSEG, S_CLRFLG, S_GP,
        S_TSAVE, S_TLINK, S_TLOAD, S_TSETNT, S_POP, S_TPOP} vme_state_type;
    typedef logic [31:0] vme_word_type;
endpackage : vme_pkg

// >>> src/vme_stack.sv
/*
 level-0 stack frame and task state image memory.
 assumes one write and one combinational read port on REF_CLK.
*/
`timescale 1ns/1ps
`include "vme_defines.svh"
module vme_stack (
    input wire logic clk, // block clock
    vme_core_if.stk c // stack port
);
    vme_pkg::vme_word_type mem [0:`VME_STK_WORDS-1];
    always_ff @(posedge clk) begin
        if (c.we) begin
            mem[c.widx] <= c.wdata;
        end
    end
    assign c.rdata = mem[c.ridx];
endmodule : vme_stack

// >>> tb/vme_entry_bench.sv
/*
 self-checking bench of the virtual mode entry engine, driven over wishbone.
 assumes the design files and the irq source model are compiled first.
*/
`timescale 1ns/1ps
`include "vme_defines.svh"
module virtual_mode_exception_entry_bench;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic raise = 1'b0, serve = 1'b0, ack, vm, gp, busy, hw;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdv, dout, seed = 32'hcfdd23d3, stk0, ss0, off, tsel, nf;
    logic [15:0] sel;
    logic [1:0] current_privilege_level;
    logic [31:0] st [9];
    logic [4:0] bad [4] = '{5'h04, 5'h08, 5'h19, 5'h03};
    int mismatches = 0, samples_checked = 0;
    always #50 clk = ~clk;
    vme_irq_src src (.clk(clk), .rst(rst), .raise(raise), .serve(serve), .hw_int(hw));
    vme_entry dut (.REF_CLK(clk), .SYS_RST(rst), .HW_INT(hw), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dout),
        .WB_ACK_O(ack), .VM_MODE(vm), .CPL_O(current_privilege_level), .GP_FAULT(gp), .BUSY(busy));
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lf
    task finish_test;
        $display("checked %0d, mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, released only at the ack edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rdv = dout;
        cyc <= 1'b0; stb <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            finish_test();
        end
    endtask : wb
    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, rdv, e);
    endtask : rc
    task idle;
        int n;
        repeat (6) @(posedge clk);
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            mismatches++;
            finish_test();
        end
    endtask : idle
    // random machine state in virtual mode at level 3, model kept in st
    task setup(input logic [4:0] g);
        for (int i = 0; i < 9; i++) begin
            seed = lf(seed);
            st[i] = seed;
        end
        st[2] = (st[2] & 32'h00003cff) | 32'h00034300;
        for (int i = 0; i < 9; i++) wr(`VME_A_ST0 + 8'(4 * i), st[i]);
        seed = lf(seed);
        stk0 = seed; sel = seed[15:0]; ss0 = {16'h0, seed[31:16]};
        seed = lf(seed);
        off = seed;
        wr(`VME_A_STK0, stk0); wr(`VME_A_SS0, ss0); wr(`VME_A_CPL, 32'h3);
        wr(`VME_A_GOFS, off);
        wr(`VME_A_GATE, {sel, 11'h0, g});
    endtask : setup
    task entry(input logic intg);
        logic [31:0] ex [9];
        idle();
        ex = '{off, {16'h0, sel}, st[2] & ~(intg ? 32'h34300 : 32'h34100), stk0 - 32'h24,
            ss0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 9; i++) rc("frame", 8'h80 + 8'(4 * i), st[i]);
        for (int i = 0; i < 9; i++) rc("entry", `VME_A_ST0 + 8'(4 * i), ex[i]);
        chk("cpl", {30'h0, current_privilege_level}, 32'h0);
        chk("vm", {31'h0, vm}, 32'h0);
    endtask : entry
    task back;
        wr(`VME_A_CTRL, 32'h4);
        idle();
        for (int i = 0; i < 9; i++) rc("return", `VME_A_ST0 + 8'(4 * i), st[i]);
        chk("vm", {31'h0, vm}, 32'h1);
        chk("gp", {31'h0, gp}, 32'h0);
        chk("cpl", {30'h0, current_privilege_level}, 32'h3);
    endtask : back
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rc("stat", `VME_A_STAT, 32'h0);
        rc("unmapped", 8'h64, 32'h0);
        wr(`VME_A_LINK, 32'hffffffff);
        rc("link ro", `VME_A_LINK, 32'h0);
        $display("test reset done");
        setup(5'h00);
        foreach (bad[j]) begin
            wr(`VME_A_GATE, {sel, 11'h0, bad[j]});
            wr(`VME_A_CTRL, 32'h2);
            idle();
            chk("fault", {31'h0, gp}, 32'h1);
            rc("error code", `VME_A_ERR, {16'h0, sel});
            rc("ip kept", `VME_A_ST0, st[0]);
            chk("vm kept", {31'h0, vm}, 32'h1);
            wr(`VME_A_STAT, 32'h2);
            rc("stat", `VME_A_STAT, 32'h30);
        end
        $display("test bad gates done");
        wr(`VME_A_GATE, {sel, 11'h0, 5'h00});
        wr(`VME_A_CTRL, 32'h2);
        entry(1'b0);
        // monitor reflects to a guest handler and hands back guest flags
        seed = lf(seed);
        st[0] = {16'h0, seed[15:0]};
        st[2] = {st[2][31:16], seed[31:16]};
        wr(8'h80, st[0]);
        wr(8'h88, st[2]);
        back();
        $display("test trap gate done");
        wr(`VME_A_CTRL, 32'h1);
        setup(5'h01);
        raise <= 1'b1;
        @(posedge clk);
        raise <= 1'b0;
        repeat (10) @(posedge clk);
        chk("masked", {30'h0, busy, vm}, 32'h1);
        wr(`VME_A_CTRL, 32'h0);
        entry(1'b1);
        serve <= 1'b1;
        @(posedge clk);
        serve <= 1'b0;
        wr(`VME_A_CPL, 32'h1);
        wr(`VME_A_CTRL, 32'h4);
        idle();
        chk("vm level1", {31'h0, vm}, 32'h0);
        rc("flags level1", `VME_A_ST0 + 8'h08, st[2] & ~32'h20000);
        $display("test interrupt gate done");
        setup(5'h02);
        seed = lf(seed);
        tsel = {16'h0, seed[15:0]};
        nf = (seed & 32'h3cff) | 32'h20000;
        wr(`VME_A_TSSC, tsel); wr(`VME_A_NTFL, nf); wr(`VME_A_CTRL, 32'h2);
        idle();
        rc("saved flags", 8'hc8, st[2]);
        rc("link", `VME_A_LINK, tsel);
        rc("task", `VME_A_TSSC, {16'h0, sel});
        rc("new flags", `VME_A_ST0 + 8'h08, (nf & ~32'h20000) | 32'h4000);
        chk("vm task", {31'h0, vm}, 32'h0);
        back();
        rc("task back", `VME_A_TSSC, tsel);
        $display("test task gate done");
        finish_test();
    end
endmodule : virtual_mode_exception_entry_bench

// >>> tb/vme_irq_src.sv
/*
 interrupt source model: holds a maskable request level until served.
 assumes raise and serve come from the bench right after a rising edge.
*/
`timescale 1ns/1ps
module vme_irq_src (
    input wire logic clk, // block clock
    input wire logic rst, // sync reset, high
    input wire logic raise, // start a request
    input wire logic serve, // handler served it
    output logic hw_int // request level
);
    logic req_ff;
    assign hw_int = req_ff;
    always_ff @(posedge clk) begin
        if (rst || serve) begin
            req_ff <= 1'b0;
        end else if (raise) begin
            req_ff <= 1'b1;
        end
    end
endmodule : vme_irq_src
